// *** verilog/serial_output_config_regs.sv ***
// Serial output configuration registers with the output formatting they steer
`timescale 1ns/1ns
`default_nettype none
module serial_output_config_regs #(
  parameter int N_CH = serial_output_config_pkg::CHANNELS,
  parameter int W = serial_output_config_pkg::SAMPLE_W
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [N_CH-1:0] chan_sel_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [N_CH*W-1:0] sample_i,
  input wire logic sample_valid_i,
  output logic [N_CH*W-1:0] dout_o,
  output logic dout_valid_o,
  input wire logic [serial_output_config_pkg::PHASE_TAPS-1:0] phase_taps_i,
  input wire logic frame_tap_i,
  output logic bit_clock_out_o,
  output logic word_framing_clock_out_o,
  output logic [N_CH-1:0] clock_drive_double_o,
  output logic lvds_low_power_o,
  output logic term_200_o,
  output logic term_100_o
);
  import serial_output_config_pkg::*;

  function automatic logic [W-1:0] fmt_word(input logic [W-1:0] w, input logic [1:0] f,
                                            input logic inv);
    logic [W-1:0] v;
    v = w;
    if (f == FMT_TWOS_COMPLEMENT) begin
      v[W-1] = ~w[W-1];
    end
    if (inv) begin
      v = ~v;
    end
    return v;
  endfunction

  function automatic int first_chan(input logic [N_CH-1:0] sel);
    int r;
    r = 0;
    for (int i = N_CH - 1; i >= 0; i--) begin
      if (sel[i]) begin
        r = i;
      end
    end
    return r;
  endfunction

  logic low_power_q;
  logic [FORMAT_W-1:0] format_q;
  logic [N_CH-1:0] invert_q;
  logic [TERM_W-1:0] term_q;
  logic [N_CH-1:0] strong_q;
  logic [PHASE_W-1:0] phase_q;
  logic [7:0] reg_rdata_q;
  logic reg_rvalid_q;
  logic [N_CH*W-1:0] dout_q;
  logic dout_valid_q;
  logic bit_clock_q;
  logic frame_clock_q;

  wire hit_cfg = (reg_addr_i == ADDR_SERIAL_OUTPUT_CONFIG);
  wire hit_drv = (reg_addr_i == ADDR_OUTPUT_DRIVE_ADJUST);
  wire hit_phase = (reg_addr_i == ADDR_BIT_CLOCK_PHASE_SELECT);
  wire wr_cfg = reg_wr_i && hit_cfg;
  wire wr_drv = reg_wr_i && hit_drv;
  wire wr_phase = reg_wr_i && hit_phase;
  wire [31:0] rd_ch = 32'(first_chan(chan_sel_i));
  wire [7:0] cfg_word = {1'b0, low_power_q, 3'b000, invert_q[rd_ch[$clog2(N_CH)-1:0]],
                         format_q};
  wire [7:0] drv_word = {2'b00, term_q, 3'b000, strong_q[rd_ch[$clog2(N_CH)-1:0]]};
  wire [7:0] phase_word = {4'h0, phase_q};
  // Unmapped addresses read as zero, so a stray poll is harmless
  wire [7:0] rd_word = hit_cfg ? cfg_word :
                       hit_drv ? drv_word :
                       hit_phase ? phase_word : 8'h00;
  // Codes past the last tap fall back to a quiet clock rather than a wrapped tap
  wire phase_legal = (phase_q <= PHASE_MAX);
  wire bit_clock_d = phase_legal ? phase_taps_i[phase_q] : 1'b0;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_power_q <= RST_SERIAL_OUTPUT_CONFIG[LOW_POWER_BIT];
      format_q <= RST_SERIAL_OUTPUT_CONFIG[FORMAT_LSB +: FORMAT_W];
      term_q <= RST_OUTPUT_DRIVE_ADJUST[TERM_LSB +: TERM_W];
      phase_q <= RST_BIT_CLOCK_PHASE_SELECT[PHASE_LSB +: PHASE_W];
    end else begin
      if (wr_cfg) begin
        low_power_q <= reg_wdata_i[LOW_POWER_BIT];
        format_q <= reg_wdata_i[FORMAT_LSB +: FORMAT_W];
      end
      if (wr_drv) begin
        term_q <= reg_wdata_i[TERM_LSB +: TERM_W];
      end
      if (wr_phase) begin
        phase_q <= reg_wdata_i[PHASE_LSB +: PHASE_W];
      end
    end
  end

  // Local bits only follow writes for the channels currently selected
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      invert_q <= {N_CH{RST_SERIAL_OUTPUT_CONFIG[INVERT_BIT]}};
      strong_q <= {N_CH{RST_OUTPUT_DRIVE_ADJUST[STRONG_BIT]}};
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        if (wr_cfg && chan_sel_i[c]) begin
          invert_q[c] <= reg_wdata_i[INVERT_BIT];
        end
        if (wr_drv && chan_sel_i[c]) begin
          strong_q[c] <= reg_wdata_i[STRONG_BIT];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_q <= rd_word;
      end
    end
  end

  // Data latching is never gated by the phase code, only the clock tap is
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dout_q <= '0;
      dout_valid_q <= 1'b0;
    end else begin
      dout_valid_q <= sample_valid_i;
      if (sample_valid_i) begin
        for (int c = 0; c < N_CH; c++) begin
          dout_q[c*W +: W] <= fmt_word(sample_i[c*W +: W], format_q, invert_q[c]);
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_clock_q <= 1'b0;
      frame_clock_q <= 1'b0;
    end else begin
      bit_clock_q <= bit_clock_d;
      frame_clock_q <= frame_tap_i;
    end
  end

  assign reg_rdata_o = reg_rdata_q;
  assign reg_rvalid_o = reg_rvalid_q;
  assign dout_o = dout_q;
  assign dout_valid_o = dout_valid_q;
  assign bit_clock_out_o = bit_clock_q;
  assign word_framing_clock_out_o = frame_clock_q;
  assign clock_drive_double_o = strong_q;
  assign lvds_low_power_o = low_power_q;
  assign term_200_o = (term_q == TERM_200_OHM);
  assign term_100_o = (term_q == TERM_100_OHM_A) || (term_q == TERM_100_OHM_B);

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  low_power_wr_a: assert property (
    wr_cfg
    |=> lvds_low_power_o == $past(reg_wdata_i[LOW_POWER_BIT]))
    else $error("low power bit not taken");

  low_power_hold_a: assert property (
    !wr_cfg
    |=> $stable(lvds_low_power_o))
    else $error("low power bit changed without a write");

  invert_data_a: assert property (
    sample_valid_i && invert_q[0] && format_q == FMT_OFFSET_BINARY
    |=> dout_o[W-1:0] == ~$past(sample_i[W-1:0]))
    else $error("inverted data wrong");

  invert_set_a: assert property (
    wr_cfg && chan_sel_i[0]
    |=> invert_q[0] == $past(reg_wdata_i[INVERT_BIT]))
    else $error("invert bit not taken");

  twos_fmt_a: assert property (
    sample_valid_i && !invert_q[0] && format_q == FMT_TWOS_COMPLEMENT
    |=> dout_o[W-1:0] == ($past(sample_i[W-1:0]) ^ {1'b1, {(W-1){1'b0}}}))
    else $error("twos complement conversion wrong");

  offset_fmt_a: assert property (
    sample_valid_i && !invert_q[0] && format_q == FMT_OFFSET_BINARY
    |=> dout_o[W-1:0] == $past(sample_i[W-1:0]))
    else $error("offset binary not passed through");

  format_hold_a: assert property (
    !wr_cfg
    |=> $stable(format_q))
    else $error("format changed without a write");

  invert_local_a: assert property (
    wr_cfg && !chan_sel_i[0]
    |=> $stable(invert_q[0]))
    else $error("unselected channel invert changed");

  format_global_a: assert property (
    wr_cfg && !chan_sel_i[0]
    |=> format_q == $past(reg_wdata_i[FORMAT_LSB +: FORMAT_W]))
    else $error("format not taken for all channels");

  term_decode_a: assert property (
    wr_drv && reg_wdata_i[TERM_LSB +: TERM_W] == TERM_200_OHM
    |=> term_200_o && !term_100_o)
    else $error("200 ohm decode wrong");

  term_100_a: assert property (
    wr_drv && reg_wdata_i[TERM_LSB + 1]
    |=> term_100_o && !term_200_o)
    else $error("100 ohm decode wrong");

  term_none_a: assert property (
    wr_drv && reg_wdata_i[TERM_LSB +: TERM_W] == TERM_NONE
    |=> !term_200_o && !term_100_o)
    else $error("no termination decode wrong");

  drive_local_a: assert property (
    wr_drv && chan_sel_i[0]
    |=> clock_drive_double_o[0] == $past(reg_wdata_i[STRONG_BIT]))
    else $error("drive strength bit not taken");

  drive_hold_a: assert property (
    !wr_drv
    |=> $stable(clock_drive_double_o))
    else $error("drive strength changed without a write");

  drive_unsel_a: assert property (
    wr_drv && !chan_sel_i[0]
    |=> $stable(clock_drive_double_o[0]))
    else $error("unselected drive bit changed");

  term_global_a: assert property (
    wr_drv && !chan_sel_i[0]
    |=> term_q == $past(reg_wdata_i[TERM_LSB +: TERM_W]))
    else $error("termination not taken for all channels");

  phase_read_a: assert property (
    wr_phase ##1 reg_rd_i && hit_phase && !wr_phase
    |=> reg_rdata_o[PHASE_LSB +: PHASE_W] == $past(reg_wdata_i[PHASE_LSB +: PHASE_W], 2))
    else $error("phase readback wrong");

  phase_hold_a: assert property (
    !wr_phase
    |=> $stable(phase_q))
    else $error("phase changed without a write");

  read_valid_a: assert property (
    reg_rd_i
    |=> reg_rvalid_o)
    else $error("read not answered");

  read_idle_a: assert property (
    !reg_rd_i
    |=> !reg_rvalid_o && $stable(reg_rdata_o))
    else $error("read data moved without a read");

  phase_tap_a: assert property (
    phase_q <= PHASE_MAX
    |=> bit_clock_out_o == $past(phase_taps_i[phase_q]))
    else $error("bit clock not from selected tap");

  frame_tap_a: assert property (
    frame_tap_i
    |=> word_framing_clock_out_o)
    else $error("frame clock not from its tap");

  latch_timing_a: assert property (
    dout_valid_o == $past(sample_valid_i))
    else $error("data latching moved");

  dout_hold_a: assert property (
    !sample_valid_i
    |=> $stable(dout_o))
    else $error("data changed without a sample");
endmodule
`default_nettype wire

// *** verilog/serial_output_config_pkg.sv ***
// Constants for the serial output configuration register bank
package serial_output_config_pkg;
  localparam logic [7:0] ADDR_SERIAL_OUTPUT_CONFIG = 8'h14;
  localparam logic [7:0] ADDR_OUTPUT_DRIVE_ADJUST = 8'h15;
  localparam logic [7:0] ADDR_BIT_CLOCK_PHASE_SELECT = 8'h16;
  localparam logic [7:0] RST_SERIAL_OUTPUT_CONFIG = 8'h00;
  localparam logic [7:0] RST_OUTPUT_DRIVE_ADJUST = 8'h00;
  localparam logic [7:0] RST_BIT_CLOCK_PHASE_SELECT = 8'h03;
  // Field positions in serial_output_config
  localparam int LOW_POWER_BIT = 6;
  localparam int INVERT_BIT = 2;
  localparam int FORMAT_LSB = 0;
  localparam int FORMAT_W = 2;
  // Field positions in output_drive_adjust
  localparam int TERM_LSB = 4;
  localparam int TERM_W = 2;
  localparam int STRONG_BIT = 0;
  // Field positions in bit_clock_phase_select
  localparam int PHASE_LSB = 0;
  localparam int PHASE_W = 4;
  localparam logic [3:0] PHASE_MAX = 4'ha;
  localparam int PHASE_TAPS = 11;
  localparam int PHASE_STEP_DEG = 60;
  typedef enum logic [1:0] {
    FMT_OFFSET_BINARY = 2'b00,
    FMT_TWOS_COMPLEMENT = 2'b01
  } format_type;
  typedef enum logic [1:0] {
    TERM_NONE = 2'b00,
    TERM_200_OHM = 2'b01,
    TERM_100_OHM_A = 2'b10,
    TERM_100_OHM_B = 2'b11
  } term_type;
  localparam int CHANNELS = 8;
  localparam int SAMPLE_W = 14;
endpackage

// *** test/output_receiver_model.sv ***
// Receiver model: feeds the clock taps and counts captured words
`timescale 1ns/1ns
`default_nettype none
module output_receiver_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic dout_valid_i,
  output logic [10:0] taps_o,
  output logic frame_tap_o,
  output int words_o
);
  // A fresh tap pattern each cycle, so a wrong phase pick cannot match by luck
  always @(negedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      taps_o <= 11'h555;
      frame_tap_o <= 1'b0;
    end else begin
      taps_o <= {taps_o[9:0], taps_o[10] ^ taps_o[8]};
      frame_tap_o <= ~frame_tap_o;
    end
  end
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) words_o <= 0;
    else if (dout_valid_i === 1'b1) words_o <= words_o + 1;
  end
endmodule
`default_nettype wire

// *** test/serial_output_config_regs_tb.sv ***
// Self-checking bench for the serial output configuration registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch %0t got %h exp %h", $time, a, e); end end
module serial_output_config_regs_tb;
  import serial_output_config_pkg::*;
  logic core_clk_i = 0, nrst_i = 0, wr = 0, rd = 0, sv = 0, ftap;
  logic rvalid, dvalid, bclk, fclk, t200, t100, lp;
  logic [7:0] addr = 0, wd = 0, sel = 0, rdata, dbl, inv = 0;
  logic [111:0] smp = 0, dout;
  logic [10:0] taps;
  logic [1:0] fmt = 0;
  logic [31:0] rs = 32'd82211;
  logic [7:0] rq[$];
  logic [111:0] dq[$];
  logic [7:0] er;
  logic [111:0] ed;
  int err_count = 0, checked = 0, nsent = 0, words;
  always #50 core_clk_i = ~core_clk_i;
  serial_output_config_regs serial_output_config_regs_inst (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd),
    .chan_sel_i(sel), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .sample_i(smp),
    .sample_valid_i(sv), .dout_o(dout), .dout_valid_o(dvalid), .phase_taps_i(taps),
    .frame_tap_i(ftap), .bit_clock_out_o(bclk), .word_framing_clock_out_o(fclk),
    .clock_drive_double_o(dbl), .lvds_low_power_o(lp), .term_200_o(t200), .term_100_o(t100));
  output_receiver_model output_receiver_model_inst (.clk_i(core_clk_i), .nrst_i(nrst_i),
    .dout_valid_i(dvalid), .taps_o(taps), .frame_tap_o(ftap), .words_o(words));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i) {wr, addr, wd} = {1'b1, a, d};
    @(negedge core_clk_i) wr = 0;
    @(negedge core_clk_i);
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk_i) {rd, addr} = {1'b1, a};
    rq.push_back(e);
    @(negedge core_clk_i) rd = 0;
  endtask
  task automatic send();
    logic [13:0] s;
    logic [111:0] e;
    @(negedge core_clk_i);
    for (int k = 0; k < 4; k++) begin
      rs = xs(rs);
      smp[k*28+:28] = rs[27:0];
    end
    for (int c = 0; c < 8; c++) begin
      s = smp[c*14+:14];
      if (fmt === FMT_TWOS_COMPLEMENT) s[13] = ~s[13];
      e[c*14+:14] = inv[c] ? ~s : s;
    end
    dq.push_back(e);
    sv = 1;
    nsent++;
    @(negedge core_clk_i) sv = 0;
  endtask
  task automatic clk_chk(input int p);
    logic t, f;
    @(negedge core_clk_i) #1 {t, f} = {taps[p], ftap};
    @(negedge core_clk_i) #1 `CHK(bclk, t)
    `CHK(fclk, f)
  endtask
  task automatic summarize();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Results are taken at the falling edge, where registered outputs have settled
  always @(negedge core_clk_i) begin
    if (rvalid === 1'b1) begin
      er = rq.pop_front();
      `CHK(rdata, er)
    end
    if (dvalid === 1'b1) begin
      ed = dq.pop_front();
      `CHK(dout, ed)
    end
  end
  initial begin
    #3000000 err_count++;
    summarize();
  end
  initial begin
    repeat (6) @(negedge core_clk_i);
    nrst_i = 1;
    rd8(ADDR_SERIAL_OUTPUT_CONFIG, RST_SERIAL_OUTPUT_CONFIG);
    rd8(ADDR_OUTPUT_DRIVE_ADJUST, RST_OUTPUT_DRIVE_ADJUST);
    rd8(ADDR_BIT_CLOCK_PHASE_SELECT, RST_BIT_CLOCK_PHASE_SELECT);
    rd8(8'h17, 8'h00);
    send();
    $display("test reset done");
    {sel, inv, fmt} = {8'h05, 8'h05, FMT_TWOS_COMPLEMENT};
    wr8(ADDR_SERIAL_OUTPUT_CONFIG, 8'h45);
    `CHK(lp, 1'b1)
    rd8(ADDR_SERIAL_OUTPUT_CONFIG, 8'h45);
    sel = 8'h02;
    rd8(ADDR_SERIAL_OUTPUT_CONFIG, 8'h41);
    send();
    send();
    fmt = FMT_OFFSET_BINARY;
    wr8(ADDR_SERIAL_OUTPUT_CONFIG, 8'h40);
    send();
    {sel, inv, fmt} = {8'h01, 8'h04, FMT_TWOS_COMPLEMENT};
    wr8(ADDR_SERIAL_OUTPUT_CONFIG, 8'h41);
    rd8(ADDR_SERIAL_OUTPUT_CONFIG, 8'h41);
    send();
    $display("test format done");
    sel = 8'h81;
    for (int c = 0; c < 4; c++) begin
      wr8(ADDR_OUTPUT_DRIVE_ADJUST, 8'h01 | 8'(c << 4));
      `CHK(t200, 1'(c == 1))
      `CHK(t100, 1'(c >= 2))
      `CHK(dbl, 8'h81)
      rd8(ADDR_OUTPUT_DRIVE_ADJUST, 8'h01 | 8'(c << 4));
    end
    sel = 8'h02;
    wr8(ADDR_OUTPUT_DRIVE_ADJUST, 8'h00);
    `CHK({dbl, t200, t100}, 10'h204)
    rd8(ADDR_OUTPUT_DRIVE_ADJUST, 8'h00);
    $display("test drive done");
    @(negedge core_clk_i) {wr, addr, wd} = {1'b1, ADDR_BIT_CLOCK_PHASE_SELECT, 8'h07};
    @(negedge core_clk_i) {wr, rd} = 2'b01;
    rq.push_back(8'h07);
    @(negedge core_clk_i) rd = 0;
    // Codes above the top tap are left alone by the host
    for (int p = 0; p <= int'(PHASE_MAX); p++) begin
      wr8(ADDR_BIT_CLOCK_PHASE_SELECT, 8'(p));
      rd8(ADDR_BIT_CLOCK_PHASE_SELECT, 8'(p));
      clk_chk(p);
      send();
    end
    repeat (3) @(negedge core_clk_i);
    `CHK(words, nsent)
    `CHK(rq.size() + dq.size(), 0)
    $display("test phase done");
    nrst_i = 0;
    repeat (2) @(negedge core_clk_i);
    `CHK({lp, dbl, t200, t100}, 11'h000)
    nrst_i = 1;
    rd8(ADDR_SERIAL_OUTPUT_CONFIG, RST_SERIAL_OUTPUT_CONFIG);
    rd8(ADDR_BIT_CLOCK_PHASE_SELECT, RST_BIT_CLOCK_PHASE_SELECT);
    clk_chk(int'(RST_BIT_CLOCK_PHASE_SELECT));
    @(negedge core_clk_i);
    `CHK(rq.size() + dq.size(), 0)
    $display("test reset again done");
    summarize();
  end
endmodule
`default_nettype wire
